// File: hw/boot_load_params.svh
// offsets, field positions, reset values and counts of the boot load control register
`ifndef BOOT_LOAD_PARAMS_SVH
`define BOOT_LOAD_PARAMS_SVH

// register location
`define BLC_OFFSET        20'h1D140

// field positions, bit 31 is the leftmost printed bit 00
`define BLC_CHAIN_BIT     31
`define BLC_WSEL_BIT      30
`define BLC_INCEN_BIT     29
`define BLC_UNLOCK_BIT    28
`define BLC_RSVD_HI       27
`define BLC_RSVD_LO       23
`define BLC_BADDR_HI      22
`define BLC_BADDR_LO      16
`define BLC_BADDR_LOW2_HI 17
`define BLC_PMODE_HI      15
`define BLC_PMODE_LO      13
`define BLC_PADDR_HI      12
`define BLC_PADDR_LO      0

// reset values
`define BLC_RST_CHAIN     1'h0
`define BLC_RST_INCEN     1'h1
`define BLC_RST_UNLOCK    1'h0
`define BLC_RST_PMODE     3'h0
`define BLC_RST_BADDR_HI  5'h14
`define BLC_RST_PADDR     13'h0000

// cycles after reset release before the synchronised straps are valid
`define STRAP_SYNC_CYCLES 2'h2

`endif

// File: hw/boot_load_pkg.sv
// types shared by the boot load addressing logic
package boot_load_pkg;

    // address phase sequencer, gray along idle -> high -> low only; low -> idle and idle -> low flip both bits
    typedef enum logic [1:0]
    {
        PH_IDLE    = 2'h0,
        PH_SEND_HI = 2'h1,
        PH_SEND_LO = 2'h3
    } addr_phase_type;

endpackage

// File: hw/i2c_boot_load_addressing.sv
// boot load control register and eeprom addressing for the i2c boot loader
//
// Summary of operation
// - width select bit: 0 gives one address byte, 1 gives two bytes
// - one byte uses offset bits 4:0 plus 000; two bytes use all 13 plus 000
// - with two address bytes the high byte goes out first
// - width select resets to the sampled address size strap
// - width select may change during loading together with a chain request
// - increment enable (reset 1) bumps device address bits 2:0 on address overflow
// - page increment only acts in one byte mode
// - on one byte wrap with increment: bump page, repeated start, new address phase
// - working device address copied at boot start and chain; increments hit the copy
// - increment enable may change during loading together with a chain request
// - unlock bit 0 (reset value) keeps device address bits 1:0 on write
// - other fields affect loading only on a write that also requests a chain
// - device address bits 1:0 latched from the board straps at power up
`timescale 1ns/1ps
`include "boot_load_params.svh"

module i2c_boot_load_addressing
#(
    parameter int         ADDR_W       = 20,
    parameter logic [4:0] BADDR_HI_RST = `BLC_RST_BADDR_HI,
    parameter logic [12:0] PADDR_RST   = `BLC_RST_PADDR
)
(
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    input  wire logic              address_size_strap,
    input  wire logic [1:0]        slave_address_straps,
    input  wire logic              regWrEn,
    input  wire logic              regRdEn,
    input  wire logic [ADDR_W-1:0] regAddr,
    input  wire logic [31:0]       regWrData,
    output logic      [31:0]       regRdData,
    input  wire logic              bootStart,
    input  wire logic              bootActive,
    input  wire logic              loadCountZero,
    input  wire logic              byteDone,
    input  wire logic              addrByteAck,
    output logic      [6:0]        deviceAddress,
    output logic      [15:0]       peripheralAddress,
    output logic                   twoByteActive,
    output logic                   readdressReq,
    output logic                   addrByteValid,
    output logic      [7:0]        addrByte,
    output logic                   strapsLatched
);

    // peripheral byte address from offset field and width select
    function automatic logic [15:0] buildAddr(input logic wide, input logic [12:0] offs);
        logic [15:0] a;
        a = 16'h0000;
        if (wide)
            a = {offs, 3'h0};
        else
            a = {8'h00, offs[4:0], 3'h0};
        return a;
    endfunction

    // strap synchronisers, the first stage feeds only the second
    logic [2:0] strapMeta_q;
    logic [2:0] strapSync_q;
    logic [1:0] strapCnt_q;
    logic [1:0] strapCnt_d;
    logic       strapDone_q;
    logic       strapDone_d;

    // register fields
    logic        chain_q,   chain_d;
    logic        widthSel_q, widthSel_d;
    logic        incEn_q,   incEn_d;
    logic        unlock_q,  unlock_d;
    logic [6:0]  bootAddr_q, bootAddr_d;
    logic [2:0]  pageMode_q, pageMode_d;
    logic [12:0] paddr_q,   paddr_d;
    logic [31:0] rdData_q,  rdData_d;

    // working state used by the load sequence
    logic        actWidthSel_q, actWidthSel_d;
    logic        actIncEn_q, actIncEn_d;
    logic [6:0]  devAddr_q,  devAddr_d;
    logic [15:0] perAddr_q,  perAddr_d;
    logic        readdr_q,   readdr_d;
    boot_load_pkg::addr_phase_type phase_q, phase_d;
    logic        abValid_q,  abValid_d;
    logic [7:0]  abByte_q,   abByte_d;

    logic        wrHit;
    logic        rdHit;
    logic        chainLoad;
    logic        loadNow;
    logic        wrapNow;
    logic [31:0] regImage;

    assign wrHit     = regWrEn && (regAddr == ADDR_W'(`BLC_OFFSET));
    assign rdHit     = regRdEn && (regAddr == ADDR_W'(`BLC_OFFSET));
    assign chainLoad = wrHit && regWrData[`BLC_CHAIN_BIT] && bootActive && loadCountZero;
    assign loadNow   = bootStart || chainLoad;
    // one byte address about to wrap back to zero
    assign wrapNow   = byteDone && !actWidthSel_q && (perAddr_q[7:0] == 8'hFF);

    // register image as read back, reserved bits zero
    always_comb
    begin
        regImage = 32'h0000_0000;
        regImage[`BLC_CHAIN_BIT]  = chain_q;
        regImage[`BLC_WSEL_BIT]   = widthSel_q;
        regImage[`BLC_INCEN_BIT]  = incEn_q;
        regImage[`BLC_UNLOCK_BIT] = unlock_q;
        regImage[`BLC_BADDR_HI:`BLC_BADDR_LO] = bootAddr_q;
        regImage[`BLC_PMODE_HI:`BLC_PMODE_LO] = pageMode_q;
        regImage[`BLC_PADDR_HI:`BLC_PADDR_LO] = paddr_q;
    end

    // strap capture counter and register next values
    always_comb
    begin
        strapCnt_d  = strapCnt_q;
        strapDone_d = strapDone_q;
        chain_d     = chain_q;
        widthSel_d  = widthSel_q;
        incEn_d     = incEn_q;
        unlock_d    = unlock_q;
        bootAddr_d  = bootAddr_q;
        pageMode_d  = pageMode_q;
        paddr_d     = paddr_q;
        rdData_d    = 32'h0000_0000;
        if (!strapDone_q)
        begin
            strapCnt_d = strapCnt_q + 2'h1;
            if (strapCnt_q == `STRAP_SYNC_CYCLES)
            begin
                strapDone_d = 1'b1;
                widthSel_d = strapSync_q[2];
                bootAddr_d[1:0] = strapSync_q[1:0];
            end
        end
        if (wrHit)
        begin
            chain_d    = regWrData[`BLC_CHAIN_BIT];
            widthSel_d = regWrData[`BLC_WSEL_BIT];
            incEn_d    = regWrData[`BLC_INCEN_BIT];
            unlock_d   = regWrData[`BLC_UNLOCK_BIT];
            pageMode_d = regWrData[`BLC_PMODE_HI:`BLC_PMODE_LO];
            paddr_d    = regWrData[`BLC_PADDR_HI:`BLC_PADDR_LO];
            bootAddr_d[6:2] = regWrData[`BLC_BADDR_HI:`BLC_BADDR_LOW2_HI+1];
            if (regWrData[`BLC_UNLOCK_BIT])
                bootAddr_d[1:0] = regWrData[`BLC_BADDR_LOW2_HI:`BLC_BADDR_LO];
        end
        if (rdHit)
            rdData_d = regImage;
    end

    // strap synchronisers and register fields
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            strapMeta_q <= 3'h0;
            strapSync_q <= 3'h0;
            strapCnt_q  <= 2'h0;
            strapDone_q <= 1'b0;
            chain_q     <= `BLC_RST_CHAIN;
            widthSel_q  <= 1'b0;
            incEn_q     <= `BLC_RST_INCEN;
            unlock_q    <= `BLC_RST_UNLOCK;
            bootAddr_q  <= {BADDR_HI_RST, 2'h0};
            pageMode_q  <= `BLC_RST_PMODE;
            paddr_q     <= PADDR_RST;
            rdData_q    <= 32'h0000_0000;
        end
        else
        begin
            strapMeta_q <= {address_size_strap, slave_address_straps};
            strapSync_q <= strapMeta_q;
            strapCnt_q  <= strapCnt_d;
            strapDone_q <= strapDone_d;
            chain_q     <= chain_d;
            widthSel_q  <= widthSel_d;
            incEn_q     <= incEn_d;
            unlock_q    <= unlock_d;
            bootAddr_q  <= bootAddr_d;
            pageMode_q  <= pageMode_d;
            paddr_q     <= paddr_d;
            rdData_q    <= rdData_d;
        end
    end

    // working copies, address counter and address phase sequencer
    always_comb
    begin
        actWidthSel_d = actWidthSel_q;
        actIncEn_d = actIncEn_q;
        devAddr_d  = devAddr_q;
        perAddr_d  = perAddr_q;
        readdr_d   = 1'b0;
        phase_d    = phase_q;
        abValid_d  = abValid_q;
        abByte_d   = abByte_q;
        if (loadNow)
        begin
            actWidthSel_d = widthSel_d;
            actIncEn_d = incEn_d;
            devAddr_d  = bootAddr_d;
            perAddr_d  = buildAddr(widthSel_d, paddr_d);
            readdr_d   = 1'b1;
        end
        else if (byteDone)
        begin
            if (actWidthSel_q)
                perAddr_d = perAddr_q + 16'h0001;
            else
                perAddr_d = {8'h00, perAddr_q[7:0] + 8'h01};
            if (wrapNow && actIncEn_q)
            begin
                devAddr_d = {devAddr_q[6:3], devAddr_q[2:0] + 3'h1};
                readdr_d  = 1'b1;
            end
        end
        if (readdr_q)
        begin
            abValid_d = 1'b1;
            if (actWidthSel_q)
            begin
                phase_d  = boot_load_pkg::PH_SEND_HI;
                abByte_d = perAddr_q[15:8];
            end
            else
            begin
                phase_d  = boot_load_pkg::PH_SEND_LO;
                abByte_d = perAddr_q[7:0];
            end
        end
        else if (addrByteAck)
        begin
            case (phase_q)
                boot_load_pkg::PH_IDLE:
                begin
                    abValid_d = 1'b0;
                end
                boot_load_pkg::PH_SEND_HI:
                begin
                    phase_d  = boot_load_pkg::PH_SEND_LO;
                    abByte_d = perAddr_q[7:0];
                end
                boot_load_pkg::PH_SEND_LO:
                begin
                    phase_d   = boot_load_pkg::PH_IDLE;
                    abValid_d = 1'b0;
                end
                default:
                begin
                    phase_d   = boot_load_pkg::PH_IDLE;
                    abValid_d = 1'b0;
                end
            endcase
        end
    end

    // working state registers
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            actWidthSel_q <= 1'b0;
            actIncEn_q <= `BLC_RST_INCEN;
            devAddr_q  <= 7'h00;
            perAddr_q  <= 16'h0000;
            readdr_q   <= 1'b0;
            phase_q    <= boot_load_pkg::PH_IDLE;
            abValid_q  <= 1'b0;
            abByte_q   <= 8'h00;
        end
        else
        begin
            actWidthSel_q <= actWidthSel_d;
            actIncEn_q <= actIncEn_d;
            devAddr_q  <= devAddr_d;
            perAddr_q  <= perAddr_d;
            readdr_q   <= readdr_d;
            phase_q    <= phase_d;
            abValid_q  <= abValid_d;
            abByte_q   <= abByte_d;
        end
    end

    // outputs straight from flops
    assign regRdData         = rdData_q;
    assign deviceAddress     = devAddr_q;
    assign peripheralAddress = perAddr_q;
    assign twoByteActive     = actWidthSel_q;
    assign readdressReq      = readdr_q;
    assign addrByteValid     = abValid_q;
    assign addrByte          = abByte_q;
    assign strapsLatched     = strapDone_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    // lock and unlock of the low device address bits
    // locked write
    AST_LOW_BITS_LOCKED: assert property (
        (wrHit && !regWrData[`BLC_UNLOCK_BIT] && strapDone_q) |=>
        (bootAddr_q[1:0] == $past(bootAddr_q[1:0])))
        else $error("low address bits changed while locked");

    AST_LOW_BITS_UNLOCKED: assert property (
        (wrHit && regWrData[`BLC_UNLOCK_BIT]) |=>
        (bootAddr_q[1:0] == $past(regWrData[`BLC_BADDR_LOW2_HI:`BLC_BADDR_LO])))
        else $error("unlocked write did not update low address bits");

    AST_RESERVED_ZERO: assert property (
        $past(rdHit) |-> (regRdData[`BLC_RSVD_HI:`BLC_RSVD_LO] == 5'h00)
        && (regRdData[`BLC_UNLOCK_BIT] == $past(unlock_q)))
        else $error("reserved bits or unlock readback wrong");

    AST_NO_BUMP_TWO_BYTE: assert property (
        (byteDone && !loadNow && actWidthSel_q) |=> $stable(devAddr_q) && !readdr_q)
        else $error("device address changed in two byte mode");

    AST_PAGE_BUMP: assert property (
        (wrapNow && actIncEn_q && !loadNow) |=>
        (devAddr_q[2:0] == $past(devAddr_q[2:0]) + 3'h1)
        && (devAddr_q[6:3] == $past(devAddr_q[6:3])) && (perAddr_q == 16'h0000))
        else $error("page bits not incremented on wrap");

    AST_WRAP_READDRESS: assert property (
        (wrapNow && actIncEn_q && !loadNow) |=> readdressReq ##1 (addrByteValid
        && addrByte == 8'h00))
        else $error("no readdress after page wrap");

    AST_NO_BUMP_DISABLED: assert property (
        (wrapNow && !actIncEn_q && !loadNow) |=> $stable(devAddr_q) && !readdr_q)
        else $error("device address changed with increment off");

    AST_HIGH_FIRST: assert property (
        (readdr_q && actWidthSel_q) |=> (addrByte == $past(perAddr_q[15:8]))
        && (phase_q == boot_load_pkg::PH_SEND_HI))
        else $error("two byte address did not start with high byte");

    AST_COPY_AT_START: assert property (
        (bootStart && !wrHit) |=> (devAddr_q == $past(bootAddr_q)) && readdressReq)
        else $error("working address not copied at boot start");

    AST_ONE_BYTE_ADDR: assert property (
        (loadNow && !widthSel_d) |=>
        (peripheralAddress == {8'h00, $past(paddr_d[4:0]), 3'h0}))
        else $error("one byte address build wrong");

    AST_STRAP_WIDTH: assert property (
        (!strapDone_q && strapCnt_q == `STRAP_SYNC_CYCLES && !wrHit) |=>
        (widthSel_q == $past(strapSync_q[2])) && strapsLatched)
        else $error("width select not taken from strap");

    COV_CHAIN: cover property (chainLoad ##1 readdressReq);
    COV_WRAP: cover property (wrapNow && actIncEn_q ##1 readdressReq);
    COV_TWO_BYTE: cover property (phase_q == boot_load_pkg::PH_SEND_HI ##[1:20]
        phase_q == boot_load_pkg::PH_SEND_LO);
    COV_UNLOCK: cover property (wrHit && regWrData[`BLC_UNLOCK_BIT]);

endmodule

// File: sim/eeprom_side_model.sv
// far side model: i2c engine with eeprom, acks address bytes and reads data bytes
`timescale 1ns/1ps

module eeprom_side_model
(
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    input  wire logic       addrByteValid,
    input  wire logic [7:0] addrByte,
    input  wire logic       readdressReq,
    input  wire logic [1:0] ackDelay,
    input  wire logic       burstGo,
    input  wire logic [9:0] burstLen,
    output logic            addrByteAck,
    output logic            byteDone,
    output logic            busy
);
    logic [1:0] waitCnt;
    logic [9:0] left;
    logic [7:0] lastByte;
    logic [7:0] prevByte;
    int         sentCnt;

    // ack each address byte after ackDelay cycles, read only outside address phases
    always @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            addrByteAck <= 1'b0;
            byteDone    <= 1'b0;
            waitCnt     <= 2'h0;
            left        <= 10'h000;
            lastByte    <= 8'h00;
            prevByte    <= 8'h00;
            sentCnt     <= 0;
        end
        else
        begin
            addrByteAck <= 1'b0;
            byteDone    <= 1'b0;
            if (addrByteValid && !addrByteAck)
            begin
                if (waitCnt == ackDelay)
                begin
                    addrByteAck <= 1'b1;
                    prevByte    <= lastByte;
                    lastByte    <= addrByte;
                    sentCnt     <= sentCnt + 1;
                    waitCnt     <= 2'h0;
                end
                else
                    waitCnt <= waitCnt + 2'h1;
            end
            // a data byte never overlaps an address phase
            if (burstGo)
                left <= burstLen;
            else if (left != 10'h000 && !addrByteValid && !readdressReq && !byteDone)
            begin
                byteDone <= 1'b1;
                left     <= left - 10'h001;
            end
        end
    end

    assign busy = (left != 10'h000);
endmodule

// File: sim/tb.sv
// self-checking bench for the boot load addressing block
`timescale 1ns/1ps
`include "boot_load_params.svh"

module tb;
    localparam logic [19:0] REG = `BLC_OFFSET;
    logic        sys_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        sizeStrap = 1'b1;
    logic [1:0]  lowStraps = 2'h2;
    logic        regWrEn = 1'b0;
    logic        regRdEn = 1'b0;
    logic [19:0] regAddr = 20'h00000;
    logic [31:0] regWrData = 32'h00000000;
    logic [31:0] regRdData;
    logic        bootStart = 1'b0;
    logic        bootActive = 1'b0;
    logic        loadCountZero = 1'b0;
    logic        byteDone;
    logic        addrByteAck;
    logic [6:0]  deviceAddress;
    logic [15:0] peripheralAddress;
    logic        twoByteActive;
    logic        readdressReq;
    logic        addrByteValid;
    logic [7:0]  addrByte;
    logic        strapsLatched;
    logic [1:0]  ackDelay = 2'h0;
    logic        burstGo = 1'b0;
    logic [9:0]  burstLen = 10'h000;
    logic        busy;
    logic [31:0] d;
    int          num_errors = 0;
    int          checks = 0;

    always #2 sys_clk = ~sys_clk;

    i2c_boot_load_addressing u_dut
    (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .address_size_strap(sizeStrap),
        .slave_address_straps(lowStraps), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
        .bootStart(bootStart), .bootActive(bootActive), .loadCountZero(loadCountZero),
        .byteDone(byteDone), .addrByteAck(addrByteAck), .deviceAddress(deviceAddress),
        .peripheralAddress(peripheralAddress), .twoByteActive(twoByteActive),
        .readdressReq(readdressReq), .addrByteValid(addrByteValid), .addrByte(addrByte),
        .strapsLatched(strapsLatched)
    );

    eeprom_side_model u_partner
    (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .addrByteValid(addrByteValid),
        .addrByte(addrByte), .readdressReq(readdressReq), .ackDelay(ackDelay),
        .burstGo(burstGo), .burstLen(burstLen), .addrByteAck(addrByteAck),
        .byteDone(byteDone), .busy(busy)
    );

    task automatic report_and_stop();
        if (num_errors == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [19:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        regWrEn   <= 1'b1;
        regAddr   <= a;
        regWrData <= v;
        @(posedge sys_clk);
        regWrEn <= 1'b0;
    endtask

    // read data shows in the cycle after the read edge
    task automatic rd(input logic [19:0] a, output logic [31:0] v);
        @(posedge sys_clk);
        regRdEn <= 1'b1;
        regAddr <= a;
        @(posedge sys_clk);
        regRdEn <= 1'b0;
        #1;
        v = regRdData;
    endtask

    // wait out address phases and data bytes, bounded
    task automatic wait_idle();
        int n;
        #1;
        for (n = 0; n < 300 && ((busy | addrByteValid | readdressReq | byteDone) !== 1'b0); n++)
        begin
            @(posedge sys_clk);
            #1;
        end
        if (n == 300)
            check(32'h1, 32'h0, "idle wait");
    endtask

    task automatic burst(input logic [9:0] n);
        @(posedge sys_clk);
        burstGo  <= 1'b1;
        burstLen <= n;
        @(posedge sys_clk);
        burstGo <= 1'b0;
        wait_idle();
    endtask

    task automatic t_reset();
        rd(REG, d);
        check(d, 32'h60520000, "reset image");
    endtask

    task automatic t_lock();
        wr(REG, 32'h6FFF0000);
        rd(REG, d);
        check(d, 32'h607E0000, "locked low bits");
        wr(REG, 32'h70810000);
        rd(REG, d);
        check(d, 32'h70010000, "unlocked low bits");
        wr(REG + 20'h4, 32'hFFFFFFFF);
        rd(REG + 20'h4, d);
        check(d, 32'h0, "unmapped read");
        rd(REG, d);
        check(d, 32'h70010000, "unmapped write");
    endtask

    task automatic t_two_byte();
        bootActive <= 1'b1;
        wr(REG, 32'h702B1FFF);
        @(posedge sys_clk);
        bootStart <= 1'b1;
        @(posedge sys_clk);
        bootStart <= 1'b0;
        wait_idle();
        check({twoByteActive, deviceAddress, peripheralAddress}, 32'hAB_FFF8, "two byte load");
        check({u_partner.prevByte, u_partner.lastByte}, 32'hFFF8, "high byte first");
        burst(10'h8);
        check({deviceAddress, peripheralAddress}, 32'h2B_0000, "no page step");
        check(u_partner.sentCnt, 32'h2, "no readdress");
    endtask

    task automatic t_wrap_chain();
        loadCountZero <= 1'b1;
        wr(REG, 32'hB0571FFF);
        wait_idle();
        check({twoByteActive, deviceAddress, peripheralAddress}, 32'h57_00F8, "chain load");
        check({u_partner.lastByte, u_partner.sentCnt[7:0]}, 32'hF803, "one byte phase");
        burst(10'h8);
        check({deviceAddress, peripheralAddress}, 32'h50_0000, "page step");
        check({u_partner.lastByte, u_partner.sentCnt[7:0]}, 32'h0004, "readdress");
        rd(REG, d);
        check(d, 32'hB0571FFF, "field kept");
    endtask

    task automatic t_page_select_increment_enable_off();
        ackDelay <= 2'h2;
        wr(REG, 32'h40570000);
        #1;
        check({31'h0, twoByteActive}, 32'h0, "no chain no load");
        wr(REG, 32'h80571FFF);
        wait_idle();
        check({deviceAddress, peripheralAddress}, 32'h57_00F8, "slow chain");
        burst(10'h8);
        check({deviceAddress, peripheralAddress}, 32'h57_0000, "no increment");
        check(u_partner.sentCnt, 32'h5, "no readdress");
    endtask

    // cut a hang short
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        report_and_stop();
    end

    initial
    begin
        repeat (8) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (5) @(posedge sys_clk);
        #1;
        check({31'h0, strapsLatched}, 32'h1, "straps latched");
        t_reset();
        t_lock();
        t_two_byte();
        t_wrap_chain();
        t_page_select_increment_enable_off();
        report_and_stop();
    end
endmodule
